// [rtl/vlan_table_defines.svh]
// Purpose: offsets, field positions, masks and counts of the vlan table access block
// Assumes: byte-wide register port; multi-byte registers are big-endian (lowest offset = msb)
// Notes: definitions only
`ifndef VLAN_TABLE_DEFINES_SVH
`define VLAN_TABLE_DEFINES_SVH

// register byte offsets (first byte of each register)
`define VT_OFS_WORD0 16'h0400
`define VT_OFS_UNTAG 16'h0404
`define VT_OFS_FWD 16'h0408
`define VT_OFS_PTR 16'h040C
`define VT_OFS_CTRL 16'h040E

// entry word 0 field positions
`define VT_VALID_BIT 31
`define VT_FO_BIT 27
`define VT_PRIO_HI 26
`define VT_PRIO_LO 24
`define VT_MSTI_HI 14
`define VT_MSTI_LO 12
`define VT_FID_HI 6
`define VT_FID_LO 0

// writable bits of each register; all others read zero
`define VT_WORD0_MASK 32'h8F00_707F
`define VT_MAP_MASK 32'h0000_0007
`define VT_PTR_MASK 16'h0FFF

// access control fields
`define VT_CTRL_START_BIT 7
`define VT_CTRL_ACT_HI 1
`define VT_CTRL_ACT_LO 0

// reset values
`define VT_WORD_RESET 32'h0000_0000
`define VT_PTR_RESET 12'h000

// table geometry
`define VT_INDEX_W 12
`define VT_DEPTH 4096
`define VT_CLEAR_LAST 12'hFFF
`define VT_PORTS 3

`endif

// [rtl/vlan_table_pkg.sv]
// Purpose: types shared by the vlan table access block
// Assumes: vlan_table_defines.svh for field positions
// Notes: state codes are gray along idle -> exec -> clear
package vlan_table_pkg;

  typedef enum logic [1:0]
  {
    ACT_NOP = 2'h0,
    ACT_WRITE = 2'h1,
    ACT_READ = 2'h2,
    ACT_CLEAR = 2'h3
  } action_t;

  typedef enum logic [1:0]
  {
    ST_IDLE = 2'h0,
    ST_EXEC = 2'h1,
    ST_CLEAR = 2'h3
  } vt_state_t;

  // one stored table entry
  typedef struct packed
  {
    logic valid;
    logic fwd_option;
    logic [2:0] priority_level;
    logic [2:0] msti;
    logic [6:0] filter_identifier;
    logic [2:0] untag;
    logic [2:0] fwd_map;
  } vlan_entry_t;

  // answer of the forwarding lookup port
  typedef struct packed
  {
    logic hit;
    logic [2:0] egress_map;
    logic [2:0] untag_map;
    logic [2:0] priority_level;
    logic [2:0] msti;
    logic [6:0] filter_identifier;
  } lookup_result_t;

  // complete register state of the block
  typedef struct packed
  {
    vt_state_t fsm;
    logic start;
    action_t action;
    logic [31:0] word0;
    logic [31:0] untag;
    logic [31:0] fwd;
    logic [11:0] index;
    logic [11:0] clr_ptr;
    logic [7:0] rd_data;
    logic lk_pend;
    logic [2:0] lk_other;
    logic lk_done;
    lookup_result_t lk_res;
  } vt_regs_t;

endpackage

// [rtl/vlan_table_access.sv]
// Purpose: staging/index registers and the 4096-entry vlan table behind them
// Assumes: one byte per register access; inputs synchronous to clk_sys
// Notes: table contents are not reset; software issues a clear-all action first
//   register writes are dropped while busy, so poll busy or the start bit between actions
//   a clear-all takes one cycle per entry after the start cycle, the table depth plus one in cycles
//   a lookup and a table write to the same entry in one cycle return the old entry
// Overview of operation
// RQ1: bit 31 of entry word 0 is the entry-valid flag, 1 valid and 0 invalid.
// RQ2: with the forward-option flag at bit 27 set, frames go only to the entry's forward map.
// RQ3: with the forward-option flag clear, egress ports come from the other port-map sources.
// RQ4: bits 26:24 of entry word 0 hold the three-bit priority of the vlan.
// RQ5: bits 14:12 of entry word 0 hold the three-bit spanning tree instance index.
// RQ6: bits 6:0 of entry word 0 hold the seven-bit filter identifier used in address hashing.
// RQ7: bits 2:0 of entry word 1 untag egress at ports 3, 2 and 1 when set.
// RQ8: bits 2:0 of entry word 2 permit forwarding to ports 3, 2 and 1 under the forward option.
// RQ9: bits 11:0 of the index register address the entry hit by the next table action.
// RQ10: setting bit 7 of the access control register starts the action; hardware clears it when done.
// RQ11: action 00 is no operation, 01 writes, 10 reads and 11 clears every entry to zero.
// RQ12: a read loads all three staging registers from the indexed entry before start clears.
// RQ13: reserved bits of the entry and index registers read zero and ignore writes.
`timescale 1ns/100ps
`include "vlan_table_defines.svh"

module vlan_table_access
  import vlan_table_pkg::*;
#(
  parameter int TABLE_DEPTH = `VT_DEPTH
)
(
  // clock, asynchronous reset and clock enable
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  // register port: one byte per access, big-endian lanes
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic busy,
  // forwarding lookup port: one request per cycle, pipelined
  input wire logic lookup_req,
  input wire logic [11:0] lookup_vid,
  input wire logic [2:0] lookup_other_map,
  output logic lookup_done,
  output lookup_result_t lookup_res
);

  // staging, index and handshake state; the table itself is plain storage
  vt_regs_t st;
  vt_regs_t next_st;

  // one entry per vlan id; only the mapped fields are stored
  vlan_entry_t table_mem [0:TABLE_DEPTH-1];
  vlan_entry_t mem_rq;
  vlan_entry_t lk_q;
  logic mem_we;
  logic [11:0] mem_waddr;
  vlan_entry_t mem_wdata;

  // merge one byte into a big-endian word, keeping only writable bits
  function automatic logic [31:0] merge_byte(input logic [31:0] old, input logic [1:0] lane,
                                             input logic [7:0] data, input logic [31:0] mask);
    logic [31:0] lane_mask;
    logic [31:0] shifted;
    lane_mask = 32'hFF00_0000 >> {lane, 3'b000};
    shifted = {data, 24'h00_0000} >> {lane, 3'b000};
    merge_byte = (old & ~(lane_mask & mask)) | (shifted & lane_mask & mask);
  endfunction

  // pick one byte of a big-endian word
  function automatic logic [7:0] pick_byte(input logic [31:0] word, input logic [1:0] lane);
    logic [31:0] shifted;
    shifted = word << {lane, 3'b000};
    pick_byte = shifted[31:24];
  endfunction

  // pack staging words into a stored entry
  function automatic vlan_entry_t stage_to_entry(input vt_regs_t s);
    vlan_entry_t e;
    e.valid = s.word0[`VT_VALID_BIT]; // RQ1
    e.fwd_option = s.word0[`VT_FO_BIT]; // RQ2
    e.priority_level = s.word0[`VT_PRIO_HI:`VT_PRIO_LO]; // RQ4
    e.msti = s.word0[`VT_MSTI_HI:`VT_MSTI_LO]; // RQ5
    e.filter_identifier = s.word0[`VT_FID_HI:`VT_FID_LO]; // RQ6
    e.untag = s.untag[`VT_PORTS-1:0]; // RQ7
    e.fwd_map = s.fwd[`VT_PORTS-1:0]; // RQ8
    stage_to_entry = e;
  endfunction

  // per-port egress choice; an invalid entry forwards nowhere, so a stale
  // map of a deleted vlan can never leak frames
  logic [`VT_PORTS-1:0] lk_egress;

  generate
    for (genvar p = 0; p < `VT_PORTS; p++)
    begin : g_egress
      assign lk_egress[p] = lk_q.valid
        && (lk_q.fwd_option ? lk_q.fwd_map[p] : st.lk_other[p]); // RQ2 RQ3
    end
  endgenerate

  // decode results and read images
  logic [15:0] ptr_word;
  logic [31:0] ctrl_word;
  logic [13:0] reg_base;
  logic hit_word0;
  logic hit_untag;
  logic hit_fwd;
  logic hit_ptr;
  logic hit_ctrl;

  // address decode; the register word is picked by the aligned base
  always_comb
  begin
    reg_base = reg_addr[15:2];
    hit_word0 = (reg_base == 14'(`VT_OFS_WORD0 >> 2));
    hit_untag = (reg_base == 14'(`VT_OFS_UNTAG >> 2));
    hit_fwd = (reg_base == 14'(`VT_OFS_FWD >> 2));
    hit_ptr = (reg_addr[15:1] == 15'(`VT_OFS_PTR >> 1));
    hit_ctrl = (reg_addr == `VT_OFS_CTRL);
    ptr_word = {4'h0, st.index} & `VT_PTR_MASK; // RQ13
    ctrl_word = {24'h00_0000, st.start, 5'h00, st.action};
  end

  // next-state logic for every register of the block
  always_comb
  begin
    // defaults: hold everything, no table write, no answer
    next_st = st;
    mem_we = 1'b0;
    mem_waddr = st.index;
    mem_wdata = stage_to_entry(st);
    next_st.lk_done = 1'b0;

    // register reads answer one cycle later; unmapped bytes read zero
    if (reg_rd)
    begin
      if (hit_word0)
        next_st.rd_data = pick_byte(st.word0 & `VT_WORD0_MASK, reg_addr[1:0]); // RQ13
      else if (hit_untag)
        next_st.rd_data = pick_byte(st.untag & `VT_MAP_MASK, reg_addr[1:0]); // RQ13
      else if (hit_fwd)
        next_st.rd_data = pick_byte(st.fwd & `VT_MAP_MASK, reg_addr[1:0]); // RQ13
      else if (hit_ptr)
        next_st.rd_data = reg_addr[0] ? ptr_word[7:0] : ptr_word[15:8];
      else if (hit_ctrl)
        next_st.rd_data = ctrl_word[7:0];
      else
        next_st.rd_data = 8'h00;
    end

    // writes are dropped while an action runs so the entry cannot change under it
    if (reg_wr && st.fsm == ST_IDLE)
    begin
      if (hit_word0)
        next_st.word0 = merge_byte(st.word0, reg_addr[1:0], reg_wdata, `VT_WORD0_MASK); // RQ13
      else if (hit_untag)
        next_st.untag = merge_byte(st.untag, reg_addr[1:0], reg_wdata, `VT_MAP_MASK); // RQ13
      else if (hit_fwd)
        next_st.fwd = merge_byte(st.fwd, reg_addr[1:0], reg_wdata, `VT_MAP_MASK); // RQ13
      // index: only the low four bits of the high byte are stored
      else if (hit_ptr && reg_addr[0])
        next_st.index[7:0] = reg_wdata; // RQ9
      else if (hit_ptr)
        next_st.index[11:8] = reg_wdata[3:0]; // RQ9
      else if (hit_ctrl)
      begin
        next_st.action = action_t'(reg_wdata[`VT_CTRL_ACT_HI:`VT_CTRL_ACT_LO]);
        if (reg_wdata[`VT_CTRL_START_BIT])
        begin
          next_st.start = 1'b1; // RQ10
          next_st.fsm = ST_EXEC;
        end
      end
    end

    // table actions; the start write and the action run in separate cycles,
    // which gives the synchronous table read one cycle to deliver mem_rq
    unique case (st.fsm)
      ST_IDLE:
      begin
        // only the register writes above move the state out of idle
      end
      ST_EXEC:
      begin
        // mem_rq already holds the indexed entry: index is frozen since start
        unique case (st.action) // RQ11
          ACT_NOP:
          begin
            // nothing to do, but the start bit still has to drop
            next_st.start = 1'b0; // RQ10
            next_st.fsm = ST_IDLE;
          end
          ACT_WRITE:
          begin
            // the staging words go to the indexed entry on this edge
            mem_we = 1'b1; // RQ9
            next_st.start = 1'b0; // RQ10
            next_st.fsm = ST_IDLE;
          end
          ACT_READ:
          begin
            // reserved staging bits come back as zero
            next_st.word0 = `VT_WORD_RESET; // RQ12
            next_st.word0[`VT_VALID_BIT] = mem_rq.valid;
            next_st.word0[`VT_FO_BIT] = mem_rq.fwd_option;
            next_st.word0[`VT_PRIO_HI:`VT_PRIO_LO] = mem_rq.priority_level;
            next_st.word0[`VT_MSTI_HI:`VT_MSTI_LO] = mem_rq.msti;
            next_st.word0[`VT_FID_HI:`VT_FID_LO] = mem_rq.filter_identifier;
            next_st.untag = {29'h0000_0000, mem_rq.untag}; // RQ12
            next_st.fwd = {29'h0000_0000, mem_rq.fwd_map}; // RQ12
            next_st.start = 1'b0; // RQ10
            next_st.fsm = ST_IDLE;
          end
          ACT_CLEAR:
          begin
            // staging registers keep their contents across a clear
            next_st.clr_ptr = 12'h000;
            next_st.fsm = ST_CLEAR;
          end
        endcase
      end
      ST_CLEAR:
      begin
        // one entry per cycle: the whole sweep takes the table depth in cycles
        mem_we = 1'b1; // RQ11
        mem_waddr = st.clr_ptr;
        mem_wdata = '0;
        next_st.clr_ptr = st.clr_ptr + 12'h001;
        if (st.clr_ptr == 12'(TABLE_DEPTH - 1))
        begin
          next_st.start = 1'b0; // RQ10
          next_st.fsm = ST_IDLE;
        end
      end
      // the unused state code falls back to idle and drops the start bit
      default:
      begin
        next_st.start = 1'b0;
        next_st.fsm = ST_IDLE;
      end
    endcase

    // forwarding lookup: request, table read, then the registered answer
    // the other-source map waits one cycle alongside the table read
    if (lookup_req)
    begin
      next_st.lk_pend = 1'b1;
      next_st.lk_other = lookup_other_map;
    end
    else
      next_st.lk_pend = 1'b0;
    if (st.lk_pend)
    begin
      next_st.lk_done = 1'b1;
      next_st.lk_res.hit = lk_q.valid; // RQ1
      next_st.lk_res.egress_map = lk_egress; // RQ2 RQ3
      // every other field is passed on as stored
      next_st.lk_res.untag_map = lk_q.untag; // RQ7
      next_st.lk_res.priority_level = lk_q.priority_level; // RQ4
      next_st.lk_res.msti = lk_q.msti; // RQ5
      next_st.lk_res.filter_identifier = lk_q.filter_identifier; // RQ6
    end
  end

  // register state
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      // zero everything: idle, no-op action, empty staging
      st <= '0;
      st.fsm <= ST_IDLE;
      st.action <= ACT_NOP;
      st.word0 <= `VT_WORD_RESET;
      st.untag <= `VT_WORD_RESET;
      st.fwd <= `VT_WORD_RESET;
      st.index <= `VT_PTR_RESET;
    end
    else if (ce)
      st <= next_st;
  end

  // table storage has no reset; two read ports, one for software and one for lookups
  // the lookup port reads by vid directly, so lookups never wait behind software
  always_ff @(posedge clk_sys)
  begin
    if (ce)
    begin
      if (mem_we)
        table_mem[mem_waddr] <= mem_wdata;
      mem_rq <= table_mem[st.index]; // RQ9
      lk_q <= table_mem[lookup_vid];
    end
  end

  // every output comes straight from the state register
  assign reg_rdata = st.rd_data;
  assign busy = st.start;
  assign lookup_done = st.lk_done;
  assign lookup_res = st.lk_res;

endmodule

// [test/vlan_table_checker.sv]
// Purpose: concurrent checks on the vlan table access ports
// Assumes: ce stays high while actions and lookups run
// Notes: bound to every vlan_table_access instance
`timescale 1ns/100ps
module vlan_table_checker
  import vlan_table_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic busy,
  input wire logic lookup_req,
  input wire logic [11:0] lookup_vid,
  input wire logic [2:0] lookup_other_map,
  input wire logic lookup_done,
  input wire lookup_result_t lookup_res
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  // a start write that idle hardware must accept
  logic go;
  assign go = ce && reg_wr && !busy && reg_addr == 16'h040E && reg_wdata[7];

  // action timing
  a_start_sets_busy: assert property (go |=> busy)
    else $error("start write did not raise busy");
  a_short_action: assert property (go && reg_wdata[1:0] != 2'h3 |=> busy ##1 !busy)
    else $error("short action did not finish in one cycle");
  a_clear_stays: assert property (go && reg_wdata[1:0] == 2'h3 |=> busy [*8])
    else $error("clear all ended too early");
  a_busy_cause: assert property ($rose(busy) |-> $past(go))
    else $error("busy rose without a start write");
  // lookup answers
  a_lookup_latency: assert property (ce && lookup_req ##1 ce |-> ##1 lookup_done)
    else $error("lookup answer not two cycles after request");
  a_miss_no_egress: assert property (lookup_done && !lookup_res.hit |->
    lookup_res.egress_map == 3'h0)
    else $error("invalid entry gave egress ports");
  // register read side
  a_rdata_holds: assert property (!$past(reg_rd) |-> $stable(reg_rdata))
    else $error("read data changed without a read");
  a_unmapped_zero: assert property (ce && reg_rd && reg_addr == 16'h040F |=>
    reg_rdata == 8'h00)
    else $error("unmapped byte read nonzero");
  a_index_reserved: assert property (ce && reg_rd && reg_addr == 16'h040C |=>
    reg_rdata[7:4] == 4'h0)
    else $error("index reserved bits read nonzero");

  c_clear: cover property (go && reg_wdata[1:0] == 2'h3);
  c_read: cover property (go && reg_wdata[1:0] == 2'h2);
  c_hit: cover property (lookup_done && lookup_res.hit);
endmodule

bind vlan_table_access vlan_table_checker u_chk (.clk_sys(clk_sys), .rst(rst), .ce(ce),
  .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .busy(busy), .lookup_req(lookup_req), .lookup_vid(lookup_vid),
  .lookup_other_map(lookup_other_map), .lookup_done(lookup_done), .lookup_res(lookup_res));

// [test/tb.sv]
// Purpose: register level test of the vlan table access block
// Assumes: ce held high; one byte per access, big-endian lanes
// Notes: clear all walks the full table depth, so the run is about 4300 cycles
`timescale 1ns/100ps
module tb import vlan_table_pkg::*;;
  logic clk_sys = 0, rst = 1, ce = 1, reg_wr = 0, reg_rd = 0, lookup_req = 0;
  logic [15:0] reg_addr = 0;
  logic [7:0] reg_wdata = 0, reg_rdata;
  logic busy, lookup_done;
  logic [11:0] lookup_vid = 0;
  logic [2:0] lookup_other_map = 0;
  lookup_result_t lookup_res;
  int num_errors = 0, n_tests = 0, cyc = 0, n;

  vlan_table_access DUT (.clk_sys(clk_sys), .rst(rst), .ce(ce), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .busy(busy), .lookup_req(lookup_req), .lookup_vid(lookup_vid),
    .lookup_other_map(lookup_other_map), .lookup_done(lookup_done), .lookup_res(lookup_res));

  // 25 MHz clock
  initial
  begin
    forever #20 clk_sys = ~clk_sys;
  end

  // hang guard, well above the single clear
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      num_errors++;
      final_report;
    end
  end

  task final_report;
    $display("errors %0d of %0d checks", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      num_errors++;
      $display("BAD %0t got %h want %h", $time, got, exp);
    end
  endtask

  // strobes drop at the next falling edge; a gap cycle avoids double drives
  task wr(input logic [15:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1;
    @(negedge clk_sys);
    reg_wr = 0;
  endtask

  task rd(input logic [15:0] a, input logic [7:0] e);
    @(negedge clk_sys);
    reg_addr = a;
    reg_rd = 1;
    @(negedge clk_sys);
    reg_rd = 0;
    chk(reg_rdata, e);
  endtask

  task wr32(input logic [15:0] a, input logic [31:0] d);
    for (int i = 0; i < 4; i++)
      wr(16'(a + i), d[31 - 8 * i -: 8]);
  endtask

  task rd32(input logic [15:0] a, input logic [31:0] e);
    for (int i = 0; i < 4; i++)
      rd(16'(a + i), e[31 - 8 * i -: 8]);
  endtask

  // start an action, optionally poke the index while busy, count busy cycles
  task act(input logic [7:0] c, input int cnt, input bit poke);
    wr(16'h040E, c);
    if (poke)
    begin
      wr(16'h040D, 8'h55);
      rd(16'h040E, c);
    end
    n = 0;
    while (busy === 1'b1 && n < 5000)
    begin
      n++;
      @(negedge clk_sys);
    end
    chk(n, cnt);
  endtask

  task look(input logic [11:0] v, input logic [2:0] o, input lookup_result_t e);
    @(negedge clk_sys);
    lookup_vid = v;
    lookup_other_map = o;
    lookup_req = 1;
    @(negedge clk_sys);
    lookup_req = 0;
    @(negedge clk_sys);
    chk(lookup_done, 1'h1);
    chk(lookup_res, e);
  endtask

  initial
  begin
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    rst = 0;
    rd32(16'h0400, 32'h0000_0000);
    rd(16'h040C, 8'h00);
    act(8'h83, 32'h0000_0FFD, 1'h1);
    rd(16'h040D, 8'h00);
    wr32(16'h0400, 32'hFFFF_FFFF);
    rd32(16'h0400, 32'h8F00_707F);
    wr32(16'h0404, 32'hFFFF_FFFF);
    rd32(16'h0404, 32'h0000_0007);
    wr(16'h040C, 8'hFF);
    rd(16'h040C, 8'h0F);
    rd(16'h040F, 8'h00);
    // entry at 0xabc: forward option with its own port map
    wr(16'h040C, 8'h0A);
    wr(16'h040D, 8'hBC);
    wr32(16'h0400, 32'h8A00_5015);
    wr32(16'h0404, 32'h0000_0005);
    wr32(16'h0408, 32'h0000_0006);
    act(8'h81, 32'h0000_0001, 1'h0);
    // entry at 0x001: other sources choose the ports
    wr(16'h040C, 8'h00);
    wr(16'h040D, 8'h01);
    wr32(16'h0400, 32'h8300_107F);
    wr32(16'h0404, 32'h0000_0002);
    wr32(16'h0408, 32'h0000_0001);
    act(8'h81, 32'h0000_0001, 1'h0);
    act(8'h80, 32'h0000_0001, 1'h0);
    // read back 0xabc over staging that still holds the other entry
    wr(16'h040C, 8'h0A);
    wr(16'h040D, 8'hBC);
    act(8'h82, 32'h0000_0001, 1'h0);
    rd32(16'h0400, 32'h8A00_5015);
    rd32(16'h0404, 32'h0000_0005);
    rd32(16'h0408, 32'h0000_0006);
    rd(16'h040E, 8'h02);
    wr(16'h040E, 8'h01);
    rd(16'h040E, 8'h01);
    chk(busy, 1'h0);
    look(12'hABC, 3'h1, lookup_result_t'{1'h1, 3'h6, 3'h5, 3'h2, 3'h5, 7'h15});
    look(12'h001, 3'h5, lookup_result_t'{1'h1, 3'h5, 3'h2, 3'h3, 3'h1, 7'h7F});
    look(12'h002, 3'h7, lookup_result_t'{1'h0, 3'h0, 3'h0, 3'h0, 3'h0, 7'h00});
    final_report;
  end
endmodule
